// File: include/swtcm_defs.vh
// constants for the service window timer and clock monitor
`ifndef SWTCM_DEFS_VH
`define SWTCM_DEFS_VH

// register byte offsets
`define SWTCM_OFF_SERVICE   4'h0
`define SWTCM_OFF_STATUS    4'h4
`define SWTCM_OFF_IDLESEL   4'h8
`define SWTCM_OFF_IDLECNT   4'hC

// service word fields
`define SWTCM_SEL_HI        7
`define SWTCM_SEL_LO        6
`define SWTCM_KEY_HI        5
`define SWTCM_KEY_LO        1
`define SWTCM_CM_BIT        0
`define SWTCM_KEY           5'h0C

// status fields
`define SWTCM_ST_PEND       0
`define SWTCM_ST_CMBAD      1
`define SWTCM_ST_WDACT      2
`define SWTCM_ST_PIN        3
`define SWTCM_ST_FIRST      4
`define SWTCM_ST_LOWER      5

// reset values
`define SWTCM_SEL_RST       2'h3
`define SWTCM_CM_RST        1'b1
`define SWTCM_TSEL_RST      3'h0
`define SWTCM_TSEL_MAX      3'h4

// timing counts
`define SWTCM_LOWER_LIM     17'h0_0800
`define SWTCM_UPPER_BASE    17'h0_2000
`define SWTCM_RELEASE_CYC   5'h18
`define SWTCM_CM_MISS       2'h2
`define SWTCM_TSEL_BASE     5'h0C

`endif

// File: core/swtcm_top.v
// service window timer with clock monitor and open-drain fault pin
`timescale 1ns/100ps
`include "swtcm_defs.vh"

// Behaviour
// - fault pin driven low only during a fault, else left to pull-up
// - timer fault: pull low until pin reads low, hold 16-32 cycles, release
// - service window restarts when fault pin returns high after a timer fault; a monitor fault does not restart it
// - service writes during an active fault output are ignored
// - pin low at power-up: timer expires, then output releases high
// - slow or absent clock holds pin low; release 16-32 cycles after good
// - monitor never flags above 5 kHz, always flags below 10 Hz
// - matching service restarts window; any field mismatch raises fault
// - both detectors inactive while reset is asserted
// - out of reset: timer and monitor enabled, largest window selected
// - window and monitor enable set only by first service after reset
// - first service must carry the correct key, else fault
// - later services must reproduce window, key and monitor fields
// - service register reads return zeros in the key field
// - timer detector suspended in halt and idle modes
// - monitor keeps running in halt and idle, flagging a stopped clock
// - after halt the selected window is reloaded
// - pending flag set on each toggle of selected idle bit; sw clears
// - idle counter not initialised by the system reset
// - automatic service at the instant idle mode is left
// - first service accepted anywhere in 64k window, no lower fault
// - return from boot code services and re-enables lower checking
// - service word: select 7:6, key 5:1, monitor enable bit 0
// - service earlier than 2048 idle clocks after previous is a fault
// - select codes 00..11 give upper limits 8k, 16k, 32k, 64k
module swtcm_top #(
   parameter CNT_W = 17
) (
   // clock, reset, enable
   input  wire        CLK_SYS_I,
   input  wire        RST_N_I,
   input  wire        POR_N_I,
   input  wire        CE_I,
   // avalon-mm slave
   input  wire [3:0]  AVS_ADDRESS_I,
   input  wire        AVS_READ_I,
   input  wire        AVS_WRITE_I,
   input  wire [31:0] AVS_WRITEDATA_I,
   input  wire [3:0]  AVS_BYTEENABLE_I,
   output reg  [31:0] AVS_READDATA_O,
   output wire        AVS_WAITREQUEST_O,
   // core status
   input  wire        IDLE_TICK_I,
   input  wire        INSTR_TICK_I,
   input  wire        HALT_I,
   input  wire        IDLE_I,
   input  wire        BOOT_I,
   // reference oscillator tick, asynchronous
   input  wire        REF_TICK_I,
   // open-drain fault pin and idle tick pending flag
   input  wire        FAULT_PIN_I,
   output wire        FAULT_OUT_N_O,
   output wire        FAULT_OE_O,
   output wire        IDLE_TICK_PENDING_O
);

   ////////////////////////////////////////////////////////////////////////
   // state codes
   localparam [1:0] WD_RUN  = 2'h0;
   localparam [1:0] WD_PULL = 2'h1;
   localparam [1:0] WD_HOLD = 2'h2;
   localparam [1:0] WD_WAIT = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   reg              pin_s1;
   reg              pin_s2;
   reg              ref_s1;
   reg              ref_s2;
   reg              ref_d;
   reg              ack;
   reg  [1:0]       wd_state;
   reg  [1:0]       next_wd_state;
   reg  [4:0]       wd_rel;
   reg  [CNT_W-1:0] win_cnt;
   reg  [CNT_W-1:0] next_win_cnt;
   reg  [1:0]       win_sel;
   reg              cm_en;
   reg              first;
   reg              lower_en;
   reg              next_first;
   reg              next_lower_en;
   reg  [1:0]       next_win_sel;
   reg              next_cm_en;
   reg  [1:0]       miss_cnt;
   reg              cm_drive;
   reg  [4:0]       cm_rel;
   reg  [CNT_W-1:0] idle_counter;
   reg  [2:0]       tick_sel;
   reg              idle_tick_pending;
   reg              halt_d;
   reg              idle_d;
   reg              boot_d;
   reg              svc_fault;
   reg              svc_ok;
   reg  [31:0]      rd_mux;

   wire             req;
   wire             wr_go;
   wire             svc_wr;
   wire             st_wr;
   wire             sel_wr;
   wire [7:0]       wbyte;
   wire             key_ok;
   wire             all_ok;
   wire             too_early;
   wire             suspended;
   wire [CNT_W-1:0] upper_lim;
   wire             expired;
   wire             fault_act;
   wire             ref_edge;
   wire             cm_bad;
   wire             wd_drive;
   wire             pin_low;
   wire [2:0]       tsel_eff;
   wire [CNT_W-1:0] idle_next;
   wire [4:0]       tbit;
   wire             tick_toggle;
   wire             halt_exit;
   wire             idle_exit;
   wire             boot_edge;
   wire             restart_evt;

   ////////////////////////////////////////////////////////////////////////
   // pin and reference synchronisers
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_d  <= 1'b0;
      end else if (CE_I) begin
         pin_s1 <= FAULT_PIN_I;
         pin_s2 <= pin_s1;
         ref_s1 <= REF_TICK_I;
         ref_s2 <= ref_s1;
         ref_d  <= ref_s2;
      end
   end

   assign pin_low  = ~pin_s2;
   assign ref_edge = ref_s2 & ~ref_d;

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then answer
   assign req               = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req & ~ack;
   assign wr_go             = AVS_WRITE_I & ack;
   assign wbyte             = AVS_WRITEDATA_I[7:0];
   assign svc_wr = wr_go & AVS_BYTEENABLE_I[0] &
                   (AVS_ADDRESS_I == `SWTCM_OFF_SERVICE);
   assign st_wr  = wr_go & AVS_BYTEENABLE_I[0] &
                   (AVS_ADDRESS_I == `SWTCM_OFF_STATUS);
   assign sel_wr = wr_go & AVS_BYTEENABLE_I[0] &
                   (AVS_ADDRESS_I == `SWTCM_OFF_IDLESEL);

   always @* begin
      rd_mux = 32'h0000_0000;
      case (AVS_ADDRESS_I)
         `SWTCM_OFF_SERVICE: begin
            rd_mux[`SWTCM_SEL_HI:`SWTCM_SEL_LO] = win_sel;
            rd_mux[`SWTCM_CM_BIT]               = cm_en;
         end
         `SWTCM_OFF_STATUS: begin
            rd_mux[`SWTCM_ST_PEND]  = idle_tick_pending;
            rd_mux[`SWTCM_ST_CMBAD] = cm_drive;
            rd_mux[`SWTCM_ST_WDACT] = (wd_state != WD_RUN);
            rd_mux[`SWTCM_ST_PIN]   = pin_s2;
            rd_mux[`SWTCM_ST_FIRST] = first;
            rd_mux[`SWTCM_ST_LOWER] = lower_en;
         end
         `SWTCM_OFF_IDLESEL: begin
            rd_mux[2:0] = tick_sel;
         end
         `SWTCM_OFF_IDLECNT: begin
            rd_mux[CNT_W-1:0] = idle_counter;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack            <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
      end else if (CE_I) begin
         ack <= req & ~ack;
         if (AVS_READ_I & ~ack) begin
            AVS_READDATA_O <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // idle counter, kept through system reset
   always @(posedge CLK_SYS_I or negedge POR_N_I) begin
      if (!POR_N_I) begin
         idle_counter <= {CNT_W{1'b0}};
      end else if (CE_I & IDLE_TICK_I) begin
         idle_counter <= idle_next;
      end
   end

   assign idle_next   = idle_counter + {{(CNT_W-1){1'b0}}, 1'b1};
   assign tsel_eff    = (tick_sel > `SWTCM_TSEL_MAX) ? `SWTCM_TSEL_MAX
                                                     : tick_sel;
   assign tbit        = `SWTCM_TSEL_BASE + {2'b00, tsel_eff};
   assign tick_toggle = IDLE_TICK_I &
                        (idle_next[tbit] != idle_counter[tbit]);

   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tick_sel          <= `SWTCM_TSEL_RST;
         idle_tick_pending <= 1'b0;
      end else if (CE_I) begin
         if (sel_wr) begin
            tick_sel <= wbyte[2:0];
         end
         if (tick_toggle) begin
            idle_tick_pending <= 1'b1;
         end else if (st_wr & wbyte[`SWTCM_ST_PEND]) begin
            idle_tick_pending <= 1'b0;
         end
      end
   end

   assign IDLE_TICK_PENDING_O = idle_tick_pending;

   ////////////////////////////////////////////////////////////////////////
   // clock monitor
   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         miss_cnt <= 2'h0;
         cm_drive <= 1'b0;
         cm_rel   <= 5'h00;
      end else if (CE_I) begin
         if (INSTR_TICK_I) begin
            miss_cnt <= 2'h0;
         end else if (ref_edge & (miss_cnt != `SWTCM_CM_MISS)) begin
            miss_cnt <= miss_cnt + 2'h1;
         end
         if (cm_bad) begin
            cm_drive <= 1'b1;
            cm_rel   <= 5'h00;
         end else if (cm_drive) begin
            if (cm_rel == `SWTCM_RELEASE_CYC) begin
               cm_drive <= 1'b0;
            end else begin
               cm_rel <= cm_rel + 5'h01;
            end
         end
      end
   end

   assign cm_bad = cm_en & (miss_cnt == `SWTCM_CM_MISS);

   ////////////////////////////////////////////////////////////////////////
   // service checks
   assign upper_lim = `SWTCM_UPPER_BASE << win_sel;
   assign suspended = HALT_I | IDLE_I;
   assign expired   = ~suspended & IDLE_TICK_I &
                      (win_cnt == upper_lim - {{(CNT_W-1){1'b0}}, 1'b1});
   assign fault_act = (wd_state != WD_RUN) | cm_drive;
   assign key_ok    = (wbyte[`SWTCM_KEY_HI:`SWTCM_KEY_LO] == `SWTCM_KEY);
   assign all_ok    = key_ok & (wbyte[`SWTCM_SEL_HI:`SWTCM_SEL_LO] == win_sel)
                      & (wbyte[`SWTCM_CM_BIT] == cm_en);
   assign too_early = lower_en & ~BOOT_I &
                      (win_cnt < `SWTCM_LOWER_LIM);
   assign halt_exit   = halt_d & ~HALT_I;
   assign idle_exit   = idle_d & ~IDLE_I;
   assign boot_edge   = boot_d ^ BOOT_I;
   assign restart_evt = halt_exit | idle_exit | boot_edge;

   always @* begin
      svc_ok        = 1'b0;
      svc_fault     = 1'b0;
      next_first    = first;
      next_win_sel  = win_sel;
      next_cm_en    = cm_en;
      next_lower_en = lower_en;
      if (svc_wr & ~fault_act) begin
         if (first) begin
            if (key_ok) begin
               svc_ok        = 1'b1;
               next_first    = 1'b0;
               next_lower_en = 1'b1;
               next_win_sel  = wbyte[`SWTCM_SEL_HI:`SWTCM_SEL_LO];
               next_cm_en    = wbyte[`SWTCM_CM_BIT];
            end else begin
               svc_fault = 1'b1;
            end
         end else if (all_ok & ~too_early) begin
            svc_ok = 1'b1;
         end else begin
            svc_fault = 1'b1;
         end
      end
      if (boot_d & ~BOOT_I) begin
         next_lower_en = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // window counter and fault sequencer
   always @* begin
      next_wd_state = wd_state;
      next_win_cnt  = win_cnt;
      case (wd_state)
         WD_RUN: begin
            if (svc_fault | expired) begin
               next_wd_state = WD_PULL;
            end else if (svc_ok | restart_evt) begin
               next_win_cnt = {CNT_W{1'b0}};
            end else if (~suspended & IDLE_TICK_I) begin
               next_win_cnt = win_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
         WD_PULL: begin
            if (pin_low) begin
               next_wd_state = WD_HOLD;
            end
         end
         WD_HOLD: begin
            if (wd_rel == `SWTCM_RELEASE_CYC) begin
               next_wd_state = WD_WAIT;
            end
         end
         WD_WAIT: begin
            if (pin_s2) begin
               next_wd_state = WD_RUN;
               next_win_cnt  = {CNT_W{1'b0}};
            end
         end
         default: begin
            next_wd_state = WD_RUN;
         end
      endcase
   end

   always @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wd_state <= WD_RUN;
         wd_rel   <= 5'h00;
         win_cnt  <= {CNT_W{1'b0}};
         win_sel  <= `SWTCM_SEL_RST;
         cm_en    <= `SWTCM_CM_RST;
         first    <= 1'b1;
         lower_en <= 1'b0;
         halt_d   <= 1'b0;
         idle_d   <= 1'b0;
         boot_d   <= 1'b0;
      end else if (CE_I) begin
         wd_state <= next_wd_state;
         win_cnt  <= next_win_cnt;
         win_sel  <= next_win_sel;
         cm_en    <= next_cm_en;
         first    <= next_first;
         lower_en <= next_lower_en;
         halt_d   <= HALT_I;
         idle_d   <= IDLE_I;
         boot_d   <= BOOT_I;
         if (wd_state == WD_HOLD) begin
            wd_rel <= wd_rel + 5'h01;
         end else begin
            wd_rel <= 5'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // open-drain fault pin
   assign wd_drive      = (wd_state == WD_PULL) | (wd_state == WD_HOLD);
   assign FAULT_OE_O    = wd_drive | cm_drive;
   assign FAULT_OUT_N_O = 1'b0;

endmodule

// File: bench/swtcm_chk_props.sv
// assertion checker on the top-level ports
`timescale 1ns/100ps
module swtcm_chk (
   // clock and resets
   input wire        CLK_SYS_I,
   input wire        RST_N_I,
   input wire        POR_N_I,
   // bus
   input wire [3:0]  AVS_ADDRESS_I,
   input wire        AVS_READ_I,
   input wire        AVS_WRITE_I,
   input wire [31:0] AVS_READDATA_O,
   input wire        AVS_WAITREQUEST_O,
   // fault pin
   input wire        FAULT_PIN_I,
   input wire        FAULT_OUT_N_O,
   input wire        FAULT_OE_O
);
   wire req     = AVS_READ_I | AVS_WRITE_I;
   wire rd_done = AVS_READ_I & ~AVS_WAITREQUEST_O;
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   ////////////////////////////////////////
   a_quiet_in_reset: assert property (disable iff (!POR_N_I)
      !RST_N_I |-> !FAULT_OE_O) else $error("fault drive in reset");
   a_open_drain_low: assert property (
      FAULT_OUT_N_O == 1'b0) else $error("pin data not low");
   a_wait_one_cycle: assert property (
      req && !$past(req) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
      else $error("bus answer not after one cycle");
   a_no_wait_idle: assert property (
      !req |-> !AVS_WAITREQUEST_O) else $error("wait without request");
   a_unmapped_zero: assert property (
      rd_done && AVS_ADDRESS_I[1:0] != 2'h0 |->
      AVS_READDATA_O == 32'h0000_0000) else $error("unmapped not zero");
   a_key_reads_zero: assert property (
      rd_done && AVS_ADDRESS_I == 4'h0 |-> AVS_READDATA_O[5:1] == 5'h00)
      else $error("key field readable");
   a_hold_after_low: assert property (
      $fell(FAULT_PIN_I) |-> FAULT_OE_O[*8] ##1 FAULT_OE_O[*8])
      else $error("release too soon after pin low");
   a_rdata_stands: assert property (
      $changed(AVS_READDATA_O) |-> $past(AVS_READ_I))
      else $error("read data moved without read");
endmodule
bind swtcm_top swtcm_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
   .POR_N_I(POR_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .FAULT_PIN_I(FAULT_PIN_I), .FAULT_OUT_N_O(FAULT_OUT_N_O),
   .FAULT_OE_O(FAULT_OE_O));

// File: bench/swtcm_pin_model.sv
// fault pin wire with pull-up and slow edges into the reset circuit
`timescale 1ns/100ps
module swtcm_pin_model #(
   parameter DLY = 3
) (
   // clock
   input  wire  clk_i,
   // open-drain drive
   input  wire  oe_i,
   input  wire  out_n_i,
   // wire level
   output logic pin_o
);
   logic [7:0] slope = 8'hFF;
   ////////////////////////////////////////
   // pull-up wins unless the block drives low
   always @(posedge clk_i) begin
      slope <= {slope[6:0], ~(oe_i & ~out_n_i)};
   end
   assign pin_o = slope[DLY-1];
endmodule

// File: bench/testbench.sv
// self-checking bench for the service window timer
`timescale 1ns/100ps
`include "swtcm_defs.vh"
module testbench;
   logic        clk, rd = 0, wr = 0, itick = 1, halt = 0, ref_t = 0;
   logic        rst_n = 0, por_n = 0, oe, out_n, pend, pin, wait_r;
   logic        idle = 0, boot = 0;
   logic        oe_s, pin_s, pend_s, wait_s;
   logic [3:0]  adr = 0;
   logic [31:0] wd = 0, rdata, rd_s, q, c1;
   int          n_fail = 0, comparisons = 0, n, i;
   int          gap [5] = '{2100, 10, 2100, 2100, 2100};
   logic [7:0]  word [5] = '{8'h18, 8'h18, 8'h58, 8'h1A, 8'h19};
   ////////////////////////////////////////
   swtcm_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n),
      .CE_I(1'b1), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'h1),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_r),
      .IDLE_TICK_I(1'b1), .INSTR_TICK_I(itick), .HALT_I(halt),
      .IDLE_I(idle), .BOOT_I(boot), .REF_TICK_I(ref_t), .FAULT_PIN_I(pin),
      .FAULT_OUT_N_O(out_n), .FAULT_OE_O(oe), .IDLE_TICK_PENDING_O(pend));
   swtcm_pin_model u_pin (.clk_i(clk), .oe_i(oe), .out_n_i(out_n),
      .pin_o(pin));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // free-running slow reference
   initial forever begin
      repeat (100) @(posedge clk);
      ref_t <= ~ref_t;
   end
   // settled copies for use at the rising edge
   always @(negedge clk) begin
      oe_s <= oe;
      pin_s <= pin;
      pend_s <= pend;
      wait_s <= wait_r;
      rd_s <= rdata;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k = 0;
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
         k++;
      end while (wait_s !== 1'b0 && k < 50);
      r = rd_s;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 50) chk("bus answer", 0, 1);
      @(posedge clk);
   endtask
   // 0 fault drive, 1 pin level, 2 pending flag
   task automatic wait_sig(input int w, input logic lvl, input int lim);
      logic s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         s = (w == 0) ? oe_s : (w == 1) ? pin_s : pend_s;
      end while (s !== lvl && n < lim);
      if (s !== lvl) chk("wait level", w, 32'hFFFF_FFFF);
   endtask
   task automatic recover();
      wait_sig(1, 0, 20);
      wait_sig(0, 0, 60);
      chk("hold after low", n >= 16 && n <= 32, 1);
      wait_sig(1, 1, 20);
   endtask
   initial begin
      #398_000;
      n_fail++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      @(posedge clk);
      bus(0, `SWTCM_OFF_SERVICE, 0, q);
      chk("reset word", q, 32'h0000_00C1);
      bus(0, `SWTCM_OFF_STATUS, 0, q);
      chk("reset status", q & 32'h0000_0030, 32'h0000_0010);
      bus(0, 4'h2, 0, q);
      chk("unmapped read", q, 0);
      bus(1, `SWTCM_OFF_SERVICE, 32'h0000_0018, q);
      repeat (20) @(posedge clk);
      chk("early first", oe_s, 0);
      bus(0, `SWTCM_OFF_SERVICE, 0, q);
      chk("kept word", q, 0);
      bus(0, `SWTCM_OFF_STATUS, 0, q);
      chk("first done", q & 32'h0000_0030, 32'h0000_0020);
      for (i = 0; i < 5; i++) begin
         repeat (gap[i]) @(posedge clk);
         bus(1, `SWTCM_OFF_SERVICE, word[i], q);
         repeat (4) @(posedge clk);
         chk("service result", oe_s, i != 0);
         if (i != 0) recover();
      end
      wait_sig(0, 1, 8300);
      chk("upper 8k", n > 8185 && n < 8205, 1);
      recover();
      repeat (2100) @(posedge clk);
      bus(1, `SWTCM_OFF_SERVICE, 32'h0000_0018, q);
      bus(1, `SWTCM_OFF_IDLESEL, 0, q);
      bus(1, `SWTCM_OFF_STATUS, 1, q);
      chk("pend clear", pend_s, 0);
      wait_sig(2, 1, 4200);
      bus(0, `SWTCM_OFF_IDLECNT, 0, q);
      c1 = q;
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, `SWTCM_OFF_IDLECNT, 0, q);
      chk("count kept", q > c1, 1);
      wait_sig(0, 1, 65600);
      chk("upper 64k", n > 65500 && n < 65560, 1);
      recover();
      halt <= 1'b1;
      itick <= 1'b0;
      repeat (700) @(posedge clk);
      chk("halt stop", oe_s, 1);
      bus(0, `SWTCM_OFF_STATUS, 0, q);
      chk("monitor flag", q[1], 1);
      halt <= 1'b0;
      itick <= 1'b1;
      wait_sig(0, 0, 60);
      chk("monitor release", n >= 16 && n <= 32, 1);
      wait_sig(1, 1, 20);
      bus(1, `SWTCM_OFF_SERVICE, 32'h0000_0018, q);
      chk("first again", oe_s, 0);
      repeat (2100) @(posedge clk);
      idle <= 1'b1;
      repeat (10) @(posedge clk);
      idle <= 1'b0;
      @(posedge clk);
      bus(1, `SWTCM_OFF_SERVICE, 32'h0000_0018, q);
      repeat (4) @(posedge clk);
      chk("idle exit service", oe_s, 1);
      recover();
      repeat (2100) @(posedge clk);
      boot <= 1'b1;
      repeat (10) @(posedge clk);
      bus(1, `SWTCM_OFF_SERVICE, 32'h0000_0018, q);
      repeat (4) @(posedge clk);
      chk("boot no lower", oe_s, 0);
      boot <= 1'b0;
      @(posedge clk);
      bus(1, `SWTCM_OFF_SERVICE, 32'h0000_0018, q);
      repeat (4) @(posedge clk);
      chk("boot exit lower", oe_s, 1);
      recover();
      close_out();
   end
endmodule
